// ---- hw/ssm_consts.svh ----
// Constants for the start-up mode strap selector
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH
// Upper five bits of the soft-mode I2C slave address (11001b)
`define SSM_I2C_ADDR_UPPER 5'h19
// Fixed 7-bit I2C slave address in ROM mode
`define SSM_I2C_ADDR_ROM 7'h64
// Address low bits chosen by the select pin level
`define SSM_ADDR_LSB_LOW 2'h0
`define SSM_ADDR_LSB_MID 2'h1
`define SSM_ADDR_LSB_HIGH 2'h2
// Bit positions of the three-level pins in the comparator vectors
`define SSM_TRI_MODE 0
`define SSM_TRI_STATUS0 1
`define SSM_TRI_STATUS1 2
`define SSM_TRI_SELECT 3
// Bit positions of the digital general pins
`define SSM_GPIO_SYNC 0
`define SSM_GPIO_STEP 2
// Reset values
`define SSM_RESET_ADDR 7'h00
`define SSM_RESET_PAGE 3'h0
`define SSM_RESET_BYTE 8'h00
// Last bit index of a serial byte
`define SSM_BYTE_LAST 3'h7
`endif

// ---- hw/ssm_pkg.sv ----
// Types shared by the start-up mode strap selector
package ssm_pkg;
	// Start-up modes picked from the mode strap
	typedef enum logic [1:0] {
		SSM_MODE_EEPROM_I2C,
		SSM_MODE_EEPROM_SPI,
		SSM_MODE_ROM_I2C
	} ssm_mode_type;
	// Decoded level of a three-level pin
	typedef enum logic [1:0] {
		SSM_LVL_LOW,
		SSM_LVL_MID,
		SSM_LVL_HIGH
	} ssm_level_type;
	// Power-on sequence states
	typedef enum logic [1:0] {
		SSM_ST_HOLD,
		SSM_ST_LOAD,
		SSM_ST_RUN
	} ssm_state_type;
endpackage

// ---- hw/ssm_link_if.sv ----
// Carrier between the core and the serial link front end
`timescale 1ns/1ps
`default_nettype none
interface ssm_link_if;
	logic [7:0] byte_data;
	logic byte_tgl;
	logic [7:0] reply_data;
	logic link_en;
	modport core (input byte_data, input byte_tgl, output reply_data, output link_en);
	modport link (output byte_data, output byte_tgl, input reply_data, input link_en);
endinterface
`default_nettype wire

// ---- hw/ssm_sync.sv ----
// Multi-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ssm_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic clk, // Destination clock
	input wire logic [WIDTH-1:0] d, // Asynchronous level in
	output logic [WIDTH-1:0] q // Synchronised level out
);
	logic [WIDTH-1:0] stage_reg [STAGES];

	initial begin
		if (STAGES < 2 || WIDTH < 1) begin
			$error("ssm_sync needs at least two stages and one bit");
		end
	end

	// First stage feeds only the next stage, never any logic
	always_ff @(posedge clk) begin
		stage_reg[0] <= d;
	end

	generate
		for (genvar i = 1; i < STAGES; i++) begin : g_stage
			always_ff @(posedge clk) begin
				stage_reg[i] <= stage_reg[i-1];
			end
		end
	endgenerate

	assign q = stage_reg[STAGES-1];
endmodule
`default_nettype wire

// ---- hw/ssm_link.sv ----
// Serial link front end running on the host serial clock
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"
module ssm_link import ssm_pkg::*; (
	input wire logic link_clk, // Serial clock from the host
	input wire logic sdi, // Serial data in
	output logic sdo, // Serial data out, from a flop
	ssm_link_if.link lk // Byte carrier to the core
);
	logic en_s;
	logic [6:0] shift_reg;
	logic [2:0] cnt_reg;
	logic [7:0] byte_reg;
	logic tgl_reg;
	logic [7:0] tx_reg;
	wire byte_end = (cnt_reg == `SSM_BYTE_LAST);
	wire [7:0] rx_full = {shift_reg, sdi};
	wire [2:0] cnt_next = cnt_reg + 3'h1;
	wire [7:0] tx_next = byte_end ? lk.reply_data : {tx_reg[6:0], 1'b0};

	// Enable level crosses in from the core domain
	ssm_sync #(.WIDTH(1), .STAGES(2)) u_en_sync (
		.clk(link_clk),
		.d(lk.link_en),
		.q(en_s)
	);

	// Bit framing; disabled link holds counters cleared
	always_ff @(posedge link_clk) begin
		if (!en_s) begin
			shift_reg <= 7'h00;
			cnt_reg <= 3'h0;
			tgl_reg <= 1'b0;
			tx_reg <= `SSM_RESET_BYTE;
		end else begin
			shift_reg <= rx_full[6:0];
			cnt_reg <= cnt_next;
			tx_reg <= tx_next;
			tgl_reg <= tgl_reg ^ byte_end;
		end
	end

	// Byte held stable until the next one, so the toggle can carry it
	always_ff @(posedge link_clk) begin
		if (!en_s) begin
			byte_reg <= `SSM_RESET_BYTE;
		end else if (byte_end) begin
			byte_reg <= rx_full;
		end
	end

	assign lk.byte_data = byte_reg;
	assign lk.byte_tgl = tgl_reg;
	assign sdo = tx_reg[7];
endmodule
`default_nettype wire

// ---- hw/ssm_top.sv ----
// Start-up mode strap selector and logic pin function mapper
// Operation
// - Sample three-level strap, pick one mode
// - Low strap: EEPROM load, I2C 11001xx
// - Select pin sets address low bits
// - EEPROM modes: general pin 0 syncs outputs
// - Low strap: general pin 2 steps up
// - Status pin 1 steps down or reports
// - Steps need trim mode and pin control
// - Floating strap: EEPROM load, SPI pins
// - High strap: ROM page from pins
// - ROM mode: fixed I2C address 0x64
// - ROM mode steps only when registers allow
// - ROM mode never enables SPI
// - Straps captured only at power-down pin release
// - Strap and status pins sampled at release
// - Status pins driven after start; pin 1 not while used as step down
// - Same register path for I2C, SPI
`timescale 1ns/1ps
`default_nettype none
`include "ssm_consts.svh"
module ssm_top import ssm_pkg::*; #(
	parameter int SYNC_STAGES = 2,
	parameter int PAGE_W = 3
) (
	input wire logic clk, // Core clock, 125 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic link_clk, // Host serial clock pin
	input wire logic power_down_reset_pin, // Low holds the block in reset
	input wire logic [3:0] tri_hi, // Three-level pins above upper threshold
	input wire logic [3:0] tri_lo, // Three-level pins below lower threshold
	input wire logic [2:0] gpio_in, // General pins as digital inputs
	input wire logic serial_data_in, // Serial data pin
	input wire logic load_done, // Register init engine finished
	input wire logic digital_freq_trim_mode, // Trim mode enabled by register
	input wire logic gpio_ctrl_en, // Pin control enabled by register
	input wire logic rom_step_en, // ROM mode step pins enabled
	input wire logic status1_step_sel, // Status pin 1 used as step down
	input wire logic [1:0] status_value, // Status levels to show
	input wire logic [7:0] reply_byte, // Reply byte for the host
	output logic [1:0] mode_code, // Captured start-up mode
	output logic regs_from_eeprom, // Initialise from EEPROM
	output logic regs_from_rom, // Initialise from ROM page
	output logic [2:0] rom_page, // Selected ROM page
	output logic load_start, // One-cycle init request
	output logic i2c_enable, // I2C interface on
	output logic spi_enable, // SPI interface on
	output logic [6:0] i2c_addr, // I2C slave address
	output logic strap_conflict, // SPI strap without mid status pins
	output logic ready, // Start-up finished
	output logic output_sync_n, // Output sync request, active low
	output logic freq_step_up_pin, // One-cycle step up request
	output logic freq_step_down_pin, // One-cycle step down request
	output logic status0_out, // Status pin 0 drive value
	output logic status0_oe, // Status pin 0 drive enable
	output logic status1_out, // Status pin 1 drive value
	output logic status1_oe, // Status pin 1 drive enable
	output logic gpio2_out, // Serial data out drive value
	output logic gpio2_oe, // Serial data out drive enable
	output logic [7:0] host_byte, // Byte received from the host
	output logic host_byte_valid, // One-cycle strobe with host_byte
	output logic host_byte_spi // Byte came over SPI
);
	initial begin
		if (SYNC_STAGES < 2 || PAGE_W != 3) begin
			$error("ssm_top needs two sync stages and a three-bit page");
		end
	end

	// Three-level decode, used for every three-level strap pin
	function automatic ssm_level_type tri_level(input logic hi, input logic lo);
		ssm_level_type lvl;
		lvl = SSM_LVL_MID;
		if (hi) begin
			lvl = SSM_LVL_HIGH;
		end else if (lo) begin
			lvl = SSM_LVL_LOW;
		end
		return lvl;
	endfunction

	ssm_link_if lk();
	logic [11:0] pin_s;
	logic tgl_s;
	logic pdn_q_reg;
	logic step_up_q_reg;
	logic step_dn_q_reg;
	logic tgl_q_reg;
	ssm_state_type state_reg, state_next;
	ssm_mode_type mode_reg;
	logic [1:0] lsb_reg;
	logic [2:0] page_reg;
	logic conflict_reg;
	logic load_start_reg;
	logic sync_n_reg;
	logic up_reg;
	logic dn_reg;
	logic [1:0] status_reg;
	logic [7:0] host_byte_reg;
	logic host_valid_reg;
	logic host_spi_reg;
	logic [7:0] reply_reg;

	// Power-down, three-level and general pins cross two flops before any logic looks at them
	ssm_sync #(.WIDTH(12), .STAGES(SYNC_STAGES)) u_pin_sync (
		.clk(clk),
		.d({power_down_reset_pin, tri_hi, tri_lo, gpio_in}),
		.q(pin_s)
	);

	// Byte toggle from the link domain
	ssm_sync #(.WIDTH(1), .STAGES(SYNC_STAGES)) u_tgl_sync (
		.clk(clk),
		.d(lk.byte_tgl),
		.q(tgl_s)
	);

	ssm_link u_link (
		.link_clk(link_clk),
		.sdi(serial_data_in),
		.sdo(gpio2_out),
		.lk(lk.link)
	);

	// Synchronised pin views
	wire pdn_s = pin_s[11];
	wire [3:0] hi_s = pin_s[10:7];
	wire [3:0] lo_s = pin_s[6:3];
	wire [2:0] gpio_s = pin_s[2:0];

	// Power-down pin low keeps the core in reset
	wire core_rst = rst | ~pdn_s;
	wire pdn_rise = pdn_s & ~pdn_q_reg;

	// Levels seen at the release edge
	wire ssm_level_type mode_lvl = tri_level(hi_s[`SSM_TRI_MODE], lo_s[`SSM_TRI_MODE]);
	wire ssm_level_type st0_lvl = tri_level(hi_s[`SSM_TRI_STATUS0], lo_s[`SSM_TRI_STATUS0]);
	wire ssm_level_type st1_lvl = tri_level(hi_s[`SSM_TRI_STATUS1], lo_s[`SSM_TRI_STATUS1]);
	wire ssm_level_type sel_lvl = tri_level(hi_s[`SSM_TRI_SELECT], lo_s[`SSM_TRI_SELECT]);

	// One mode per strap level
	wire ssm_mode_type mode_next = (mode_lvl == SSM_LVL_LOW) ? SSM_MODE_EEPROM_I2C :
		(mode_lvl == SSM_LVL_MID) ? SSM_MODE_EEPROM_SPI : SSM_MODE_ROM_I2C;
	wire [1:0] lsb_next = (sel_lvl == SSM_LVL_LOW) ? `SSM_ADDR_LSB_LOW :
		(sel_lvl == SSM_LVL_MID) ? `SSM_ADDR_LSB_MID : `SSM_ADDR_LSB_HIGH;
	// SPI is only safe when the host floated the status pins as well
	wire conflict_next = (mode_lvl == SSM_LVL_MID) &
		((st0_lvl != SSM_LVL_MID) | (st1_lvl != SSM_LVL_MID));

	// Mode decode
	wire run = (state_reg == SSM_ST_RUN);
	wire is_eep_i2c = (mode_reg == SSM_MODE_EEPROM_I2C);
	wire is_spi = (mode_reg == SSM_MODE_EEPROM_SPI);
	wire is_rom = (mode_reg == SSM_MODE_ROM_I2C);
	wire cs_active = lo_s[`SSM_TRI_SELECT];

	// Step pins need both register enables; ROM mode a third
	wire step_ok = run & digital_freq_trim_mode & gpio_ctrl_en &
		(is_eep_i2c | (is_rom & rom_step_en));
	wire dn_pin_in = step_ok & status1_step_sel;
	wire up_in = gpio_s[`SSM_GPIO_STEP];
	wire dn_in = hi_s[`SSM_TRI_STATUS1];
	wire up_rise = up_in & ~step_up_q_reg;
	wire dn_rise = dn_in & ~step_dn_q_reg;

	// Host byte arrives when the toggle changes
	wire byte_evt = run & (tgl_s ^ tgl_q_reg);

	// Sequence: hold in reset, ask for the load, then run
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SSM_ST_HOLD: begin
				if (pdn_rise) begin
					state_next = SSM_ST_LOAD;
				end
			end
			SSM_ST_LOAD: begin
				if (load_done) begin
					state_next = SSM_ST_RUN;
				end
			end
			SSM_ST_RUN: begin
				state_next = SSM_ST_RUN;
			end
			default: begin
				state_next = SSM_ST_HOLD;
			end
		endcase
	end

	// Edge history; runs on the plain reset so the release edge is seen
	always_ff @(posedge clk) begin
		if (rst) begin
			pdn_q_reg <= 1'b0;
		end else begin
			pdn_q_reg <= pdn_s;
		end
	end

	always_ff @(posedge clk) begin
		if (core_rst) begin
			state_reg <= SSM_ST_HOLD;
			load_start_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			load_start_reg <= pdn_rise & (state_reg == SSM_ST_HOLD);
		end
	end

	// Straps are taken once, at the release edge, and then kept
	always_ff @(posedge clk) begin
		if (core_rst) begin
			mode_reg <= SSM_MODE_EEPROM_I2C;
			lsb_reg <= `SSM_ADDR_LSB_LOW;
			page_reg <= `SSM_RESET_PAGE;
			conflict_reg <= 1'b0;
		end else if (pdn_rise && state_reg == SSM_ST_HOLD) begin
			mode_reg <= mode_next;
			lsb_reg <= lsb_next;
			page_reg <= gpio_s;
			conflict_reg <= conflict_next;
		end
	end

	// Pin functions after start-up
	always_ff @(posedge clk) begin
		if (core_rst) begin
			sync_n_reg <= 1'b1;
			up_reg <= 1'b0;
			dn_reg <= 1'b0;
			step_up_q_reg <= 1'b0;
			step_dn_q_reg <= 1'b0;
			status_reg <= 2'h0;
		end else begin
			sync_n_reg <= ~(run & ~is_rom & ~gpio_s[`SSM_GPIO_SYNC]);
			up_reg <= step_ok & up_rise;
			dn_reg <= dn_pin_in & dn_rise;
			step_up_q_reg <= up_in;
			step_dn_q_reg <= dn_in;
			status_reg <= status_value;
		end
	end

	// Host bytes from either interface land in one stream
	always_ff @(posedge clk) begin
		if (core_rst) begin
			tgl_q_reg <= 1'b0;
			host_byte_reg <= `SSM_RESET_BYTE;
			host_valid_reg <= 1'b0;
			host_spi_reg <= 1'b0;
			reply_reg <= `SSM_RESET_BYTE;
		end else begin
			tgl_q_reg <= tgl_s;
			host_valid_reg <= byte_evt;
			if (byte_evt) begin
				host_byte_reg <= lk.byte_data;
				host_spi_reg <= is_spi;
				// Reply changes only here, well before the link loads it
				reply_reg <= reply_byte;
			end
		end
	end

	// Link runs only once the interface of the mode is enabled
	assign lk.link_en = run;
	assign lk.reply_data = reply_reg;

	// Mode outputs
	assign mode_code = mode_reg;
	assign regs_from_eeprom = ~is_rom;
	assign regs_from_rom = is_rom;
	assign rom_page = page_reg;
	assign load_start = load_start_reg;
	assign i2c_enable = run & ~is_spi;
	assign spi_enable = run & is_spi;
	assign i2c_addr = is_rom ? `SSM_I2C_ADDR_ROM :
		is_spi ? `SSM_RESET_ADDR : {`SSM_I2C_ADDR_UPPER, lsb_reg};
	assign strap_conflict = conflict_reg;
	assign ready = run;

	// Pin drives; status pins override strap bias once running, pin 1 not while used as step down
	assign output_sync_n = sync_n_reg;
	assign freq_step_up_pin = up_reg;
	assign freq_step_down_pin = dn_reg;
	assign status0_out = status_reg[0];
	assign status0_oe = run;
	assign status1_out = status_reg[1];
	assign status1_oe = run & ~dn_pin_in;
	assign gpio2_oe = run & is_spi & cs_active;

	// Host stream outputs
	assign host_byte = host_byte_reg;
	assign host_byte_valid = host_valid_reg;
	assign host_byte_spi = host_spi_reg;
endmodule
`default_nettype wire

// ---- sim/ssm_top_chk.sv ----
// Port-level checks for the strap selector top
`timescale 1ns/1ps
`default_nettype none
module ssm_top_chk (
	input wire logic clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic power_down_reset_pin, // Power pin
	input wire logic digital_freq_trim_mode, // Trim enable
	input wire logic gpio_ctrl_en, // Pin control enable
	input wire logic [1:0] mode_code, // Mode
	input wire logic [6:0] i2c_addr, // Address
	input wire logic [2:0] rom_page, // Page
	input wire logic load_start, // Init pulse
	input wire logic i2c_enable, // I2C on
	input wire logic spi_enable, // SPI on
	input wire logic ready, // Running
	input wire logic output_sync_n, // Sync out
	input wire logic freq_step_up_pin, // Step up
	input wire logic status0_oe // Status drive
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_soft_addr: assert property (ready && mode_code == 2'h0 |-> i2c_addr[6:2] == 5'h19 && i2c_enable)
		else $error("soft mode address wrong");
	a_rom_fixed_addr: assert property (ready && mode_code == 2'h2 |-> i2c_addr == 7'h64 && !spi_enable)
		else $error("rom mode address wrong");
	a_spi_only: assert property (ready && mode_code == 2'h1 |-> spi_enable && !i2c_enable)
		else $error("spi mode enables wrong");
	a_mode_held: assert property (ready && $past(ready) |-> $stable(mode_code) && $stable(i2c_addr) && $stable(rom_page))
		else $error("mode changed while running");
	a_step_pulse: assert property (freq_step_up_pin |=> !freq_step_up_pin)
		else $error("step pulse too long");
	a_step_gate: assert property (freq_step_up_pin |-> $past(digital_freq_trim_mode) && $past(gpio_ctrl_en))
		else $error("step without enables");
	a_spi_no_step: assert property (freq_step_up_pin |-> ready && mode_code != 2'h1)
		else $error("step in spi mode");
	a_rom_no_sync: assert property (ready && mode_code == 2'h2 |-> output_sync_n)
		else $error("sync in rom mode");
	a_load_once: assert property (load_start |=> !load_start)
		else $error("load pulse too long");
	a_status_drive: assert property (ready && $past(ready) |-> status0_oe)
		else $error("status pin not driven");
	a_pdn_holds: assert property (!power_down_reset_pin [*5] |-> !ready && !i2c_enable && !spi_enable)
		else $error("running while powered down");
endmodule
bind ssm_top ssm_top_chk ssm_top_chk_inst (.clk, .rst, .power_down_reset_pin, .digital_freq_trim_mode,
	.gpio_ctrl_en, .mode_code, .i2c_addr, .rom_page, .load_start, .i2c_enable, .spi_enable, .ready,
	.output_sync_n, .freq_step_up_pin, .status0_oe);
`default_nettype wire

// ---- sim/ssm_host_model.sv ----
// Host side serial model: clocks bytes in and reads the reply line
`timescale 1ns/1ps
`default_nettype none
module ssm_host_model (
	input wire logic sdo, // Reply line from the block
	output logic link_clk, // Serial clock, still between frames
	output logic sdi // Serial data to the block
);
	initial begin
		link_clk = 1'b0;
		sdi = 1'b1;
	end
	// Idle clocks: a few while the core is held flush the link side clean,
	// two after enable let the synchronised enable settle before the first bit
	task automatic wake(input int n);
		repeat (n) begin
			#6 link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
	endtask
	// MSB first at 12 ns; reply bit read just before each rising edge
	task automatic xfer(input logic [7:0] b, output logic [7:0] r);
		#3.3;
		for (int i = 7; i >= 0; i--) begin
			sdi = b[i];
			#6;
			r = {r[6:0], sdo};
			link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
		sdi = ~sdi; // Released line must not look like held data
	endtask
endmodule
`default_nettype wire

// ---- sim/ssm_top_tb_top.sv ----
// Self-checking bench for the strap selector top
`timescale 1ns/1ps
`default_nettype none
module ssm_top_tb_top;
	import ssm_pkg::*;
	logic clk = 1'b0, rst = 1'b1, power_down_reset_pin = 1'b0, load_done = 1'b0;
	logic [3:0] tri_hi = 4'h0, tri_lo = 4'h0;
	logic [2:0] gpio_in = 3'h1, rom_page;
	logic digital_freq_trim_mode = 1'b0, gpio_ctrl_en = 1'b0, rom_step_en = 1'b1;
	logic link_clk, serial_data_in;
	logic [1:0] mode_code, lv;
	logic [6:0] i2c_addr;
	logic [7:0] host_byte, r;
	logic regs_from_eeprom, regs_from_rom, load_start, i2c_enable, spi_enable, strap_conflict;
	logic ready, output_sync_n, freq_step_up_pin, freq_step_down_pin, status0_out, status0_oe;
	logic status1_out, status1_oe, gpio2_out, gpio2_oe, host_byte_valid, host_byte_spi;
	int err_total = 0, n_checks = 0, cyc = 0, nu, nd, seen;
	always #4 clk = ~clk;
	ssm_top ssm_top_inst (.clk, .rst, .link_clk, .power_down_reset_pin, .tri_hi, .tri_lo, .gpio_in,
		.serial_data_in, .load_done, .digital_freq_trim_mode, .gpio_ctrl_en, .rom_step_en,
		.status1_step_sel(1'b1), .status_value(2'h1), .reply_byte(8'hA5), .mode_code,
		.regs_from_eeprom, .regs_from_rom, .rom_page, .load_start, .i2c_enable, .spi_enable,
		.i2c_addr, .strap_conflict, .ready, .output_sync_n, .freq_step_up_pin, .freq_step_down_pin,
		.status0_out, .status0_oe, .status1_out, .status1_oe, .gpio2_out, .gpio2_oe, .host_byte,
		.host_byte_valid, .host_byte_spi);
	// Undriven data out line reads as the inverse, so a missing drive is caught
	ssm_host_model ssm_host_model_inst (.sdo(gpio2_oe ? gpio2_out : ~gpio2_out), .link_clk,
		.sdi(serial_data_in));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// Three-level pin: hi comparator for high, lo comparator for low, neither for mid
	task automatic set_pin(input int p, input logic [1:0] l);
		tri_hi[p] = (l == SSM_LVL_HIGH);
		tri_lo[p] = (l == SSM_LVL_LOW);
	endtask
	// Raise both step inputs and count pulses over a bounded window
	task automatic step(input logic t, input int ex);
		digital_freq_trim_mode = t;
		gpio_ctrl_en = 1'b1;
		gpio_in[2] = 1'b1;
		set_pin(2, 2'h2);
		nu = 0;
		nd = 0;
		repeat (8) @(negedge clk) begin
			nu += freq_step_up_pin;
			nd += freq_step_down_pin;
		end
		chk(nu === ex, "step up count");
		chk(nd === ex, "step down count");
		chk(status1_oe === (ex == 0), "status1 drive");
		gpio_in[2] = 1'b0;
		set_pin(2, 2'h1);
		repeat (4) @(negedge clk);
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			$display("[FAIL] %0t timeout", $time);
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			power_down_reset_pin = 1'b0;
			load_done = 1'b0;
			lv = (i < 3) ? 2'h0 : (i < 5) ? 2'h1 : 2'h2;
			set_pin(0, lv);
			set_pin(3, (i < 3) ? i[1:0] : 2'h0);
			set_pin(1, (i == 4) ? 2'h2 : 2'h1);
			set_pin(2, 2'h1);
			gpio_in = 3'h5;
			repeat (6) @(negedge clk);
			// Link clocked while the core is held, so its counters start cleared
			ssm_host_model_inst.wake(4);
			@(negedge clk);
			power_down_reset_pin = 1'b1;
			seen = 0;
			repeat (8) @(negedge clk) seen += load_start;
			chk(seen === 1, "load pulse");
			chk(mode_code === lv, "mode");
			chk(i2c_addr === (lv == 2'h0 ? {5'h19, i[1:0]} : lv == 2'h2 ? 7'h64 : 7'h00), "addr");
			chk(regs_from_eeprom === (lv != 2'h2) && regs_from_rom === (lv == 2'h2), "source");
			chk(lv != 2'h2 || rom_page === 3'h5, "page");
			chk(strap_conflict === (i == 4), "conflict");
			set_pin(0, 2'h2 - lv);
			gpio_in = 3'h1;
			load_done = 1'b1;
			seen = 0;
			while (ready !== 1'b1 && seen < 20) @(negedge clk) seen++;
			@(negedge clk);
			chk(mode_code === lv, "mode held");
			chk(i2c_enable === (lv != 2'h1) && spi_enable === (lv == 2'h1), "enables");
			chk(status0_oe === 1'b1, "status drive");
			chk(status0_out === 1'b1 && status1_out === 1'b0, "status levels");
			chk(gpio2_oe === (lv == 2'h1), "sdo drive");
			gpio_in[0] = 1'b0;
			repeat (5) @(negedge clk);
			chk(output_sync_n === (lv == 2'h2), "sync");
			gpio_in[0] = 1'b1;
			step(1'b0, 0);
			step(1'b1, (lv != 2'h1) ? 1 : 0);
			// ROM mode with the register enable off: no steps at all
			if (lv == 2'h2) begin
				rom_step_en = 1'b0;
				step(1'b1, 0);
				rom_step_en = 1'b1;
			end
			ssm_host_model_inst.wake(2);
			for (int k = 0; k < 3; k++) begin
				ssm_host_model_inst.xfer(8'h3C + k[7:0], r);
				seen = 0;
				while (host_byte_valid !== 1'b1 && seen < 12) @(negedge clk) seen++;
				chk(host_byte === 8'h3C + k[7:0], "host byte");
				chk(host_byte_spi === (lv == 2'h1), "byte path");
			end
			chk(lv != 2'h1 || r === 8'hA5, "reply");
		end
		final_report();
	end
endmodule
`default_nettype wire
